// *** rtl/dmrc_map.vh ***
/*
 * constants for the command decoder: command codes, mode register select,
 * field positions and timing counts.
 * assumes inclusion by bare name from rtl design files.
 */
`ifndef DMRC_MAP_VH
`define DMRC_MAP_VH

// ----------------------------------------------------------------
// command pin patterns {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define DMRC_CMD_MRS 4'h0
`define DMRC_CMD_REF 4'h1
`define DMRC_CMD_PRE 4'h2
`define DMRC_CMD_ACT 4'h3
`define DMRC_CMD_WR 4'h4
`define DMRC_CMD_RD 4'h5
`define DMRC_CMD_NOP 4'h7
`define DMRC_CMD_RSVD 4'h6

// ----------------------------------------------------------------
// mode register select on bank address
// ----------------------------------------------------------------
`define DMRC_BA_MR 2'h0
`define DMRC_BA_EMR1 2'h1
`define DMRC_BA_EMR2 2'h2
`define DMRC_BA_EMR3 2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DMRC_A_PRE_ALL 10
`define DMRC_A_HOT_SRF 7
`define DMRC_A_ROW_TOP 13
`define DMRC_A_OUT_DIS 12
`define DMRC_A_RSTROBE 11
`define DMRC_OCD_HI 9
`define DMRC_OCD_LO 7
`define DMRC_A_COL_HI 9
`define DMRC_A_PARTIAL_REGION_SELECT_HI 2
`define DMRC_EMR2_RSVD_MASK 14'h3_F78
`define DMRC_EMR3_RSVD_MASK 14'h3_FFF
`define DMRC_OCD_EXIT 3'h0
`define DMRC_OCD_DEFAULT 3'h7

// ----------------------------------------------------------------
// region codes and timing
// ----------------------------------------------------------------
`define DMRC_PARTIAL_REGION_SELECT_FULL 3'h0
`define DMRC_PARTIAL_REGION_SELECT_UNDEF 3'h3
`define DMRC_READ_BLOCK_CLKS 8'hC8
`define DMRC_BANKS_NONE 4'h0
`define DMRC_CNT_W 8
`define DMRC_RESET_ZERO 14'h0_000

`endif

// *** rtl/dmrc_edge_sync.v ***
/*
 * two-flop synchroniser with rising edge detector for the memory clock.
 * assumes the sampled clock is much slower than core_clk.
 */
`timescale 1ns/10ps
module dmrc_edge_sync (
	input wire core_clk,
	input wire rst_b,
	input wire din,
	output reg dout_q,
	output reg rise_q
);
	reg meta_q;
	reg prev_q;

	always @(posedge core_clk) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			dout_q <= 1'b0;
			prev_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			meta_q <= din;
			dout_q <= meta_q;
			prev_q <= dout_q;
			rise_q <= dout_q & ~prev_q;
		end
	end
endmodule // dmrc_edge_sync

// *** rtl/dmrc_bus_sync.v ***
/*
 * two-flop synchroniser for the command and address pins.
 * assumes pins are stable around each memory clock rising edge.
 */
`timescale 1ns/10ps
module dmrc_bus_sync #(
	parameter W = 21
) (
	input wire core_clk,
	input wire rst_b,
	input wire [W-1:0] din,
	output reg [W-1:0] dout_q
);
	reg [W-1:0] meta_q;

	always @(posedge core_clk) begin
		if (!rst_b) begin
			meta_q <= {W{1'b0}};
			dout_q <= {W{1'b0}};
		end else begin
			meta_q <= din;
			dout_q <= meta_q;
		end
	end
endmodule // dmrc_bus_sync

// *** rtl/dmrc_decode.v ***
/*
 * command decoder and extended mode register keeper of a ddr2 memory.
 * samples the pins at rising edges of the memory clock as seen by core_clk.
 * assumes mem_ck is much slower than core_clk and the pins stay stable
 * across several core cycles around each rising edge.
 */
`timescale 1ns/10ps
`include "dmrc_map.vh"
module dmrc_decode #(
	parameter WIDE_PART = 1'b0
) (
	input wire core_clk,
	input wire rst_b,
	input wire mem_ck,
	input wire cke,
	input wire cs_b,
	input wire ras_b,
	input wire cas_b,
	input wire we_b,
	input wire [1:0] ba,
	input wire [13:0] addr,
	output reg hot_selfrefresh_rate_en,
	output reg [2:0] partial_region_select,
	output reg [13:0] refresh_feature_mode_q,
	output reg [13:0] spare_mode_three_q,
	output reg emr2_valid_q,
	output reg emr3_valid_q,
	output reg out_disable_q,
	output reg ocd_cal_active_q,
	output reg cmd_strobe_q,
	output reg [3:0] cmd_code_q,
	output reg [1:0] cmd_bank_q,
	output reg [13:0] cmd_row_q,
	output reg [9:0] cmd_col_q,
	output reg cmd_auto_pre_q,
	output reg cmd_pre_all_q,
	output reg in_self_refresh_q,
	output reg in_power_down_q,
	output reg region_limited_q,
	output reg illegal_q
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire ck_rise;
	wire [20:0] pins_s;

	dmrc_edge_sync u_ck (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.din(mem_ck),
		.dout_q(),
		.rise_q(ck_rise)
	);

	// ck_rise lags the clock by one more stage than the pins: sampled pins
	// are those just after the edge, fine for slow, held command pins
	dmrc_bus_sync #(.W(21)) u_pins (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.din({cke, cs_b, ras_b, cas_b, we_b, ba, addr}),
		.dout_q(pins_s)
	);

	wire cke_s = pins_s[20];
	wire [3:0] cmd_s = pins_s[19:16];
	wire [1:0] ba_s = pins_s[15:14];
	wire [13:0] a_s = pins_s[13:0];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function is_idle_cmd;
		input [3:0] c;
		begin
			is_idle_cmd = c[3] | (c == `DMRC_CMD_NOP);
		end
	endfunction

	// one-hot bank mask from a bank address
	function [3:0] bank_bit;
		input [1:0] b;
		begin
			bank_bit = 4'h1 << b;
		end
	endfunction

	// ----------------------------------------------------------------
	// device state machine, one-hot
	// ----------------------------------------------------------------
	localparam [2:0] ST_RUN = 3'b001;
	localparam [2:0] ST_PD = 3'b010;
	localparam [2:0] ST_SR = 3'b100;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg cke_prev_q;
	reg [`DMRC_CNT_W-1:0] rd_block_q;
	reg bad_d;
	reg exec_d;

	always @* begin
		state_d = state_q;
		bad_d = 1'b0;
		exec_d = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (!cke_prev_q) begin
					bad_d = 1'b1;
				end else if (!cke_s) begin
					if (is_idle_cmd(cmd_s)) begin
						state_d = ST_PD;
					end else if (cmd_s == `DMRC_CMD_REF) begin
						state_d = ST_SR;
					end else begin
						bad_d = 1'b1;
					end
				end else begin
					exec_d = ~cmd_s[3];
					if (cmd_s == `DMRC_CMD_RSVD) begin
						bad_d = 1'b1;
					end
					if ((cmd_s == `DMRC_CMD_RD) && (rd_block_q != {`DMRC_CNT_W{1'b0}})) begin
						bad_d = 1'b1;
					end
				end
			end
			ST_PD, ST_SR: begin
				if (cke_s) begin
					if (is_idle_cmd(cmd_s)) begin
						state_d = ST_RUN;
					end else begin
						bad_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// open bank tracking
	// ----------------------------------------------------------------
	// rows opened by activate are tracked only to catch a mode register
	// load or self refresh entry with a row still open; no timing is kept
	reg [3:0] bank_open_q;
	reg [3:0] bank_open_d;
	reg open_bad_d;

	always @* begin
		bank_open_d = bank_open_q;
		open_bad_d = 1'b0;
		if (exec_d) begin
			case (cmd_s)
				`DMRC_CMD_ACT: begin
					bank_open_d = bank_open_q | bank_bit(ba_s);
				end
				`DMRC_CMD_PRE: begin
					if (a_s[`DMRC_A_PRE_ALL]) begin
						bank_open_d = `DMRC_BANKS_NONE;
					end else begin
						bank_open_d = bank_open_q & ~bank_bit(ba_s);
					end
				end
				`DMRC_CMD_MRS: begin
					// a load with a row open is unspecified, so flagged
					open_bad_d = (bank_open_q != `DMRC_BANKS_NONE);
				end
				default: begin
					bank_open_d = bank_open_q;
				end
			endcase
		end
		if ((state_q == ST_RUN) && (state_d == ST_SR) &&
			(bank_open_q != `DMRC_BANKS_NONE)) begin
			open_bad_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers and decoded outputs
	// ----------------------------------------------------------------
	wire is_mrs = exec_d && (cmd_s == `DMRC_CMD_MRS);
	wire [13:0] row_eff = WIDE_PART ?
		{1'b0, a_s[`DMRC_A_ROW_TOP-1:0]} : a_s;
	wire [2:0] ocd_f = a_s[`DMRC_OCD_HI:`DMRC_OCD_LO];

	always @(posedge core_clk) begin
		if (!rst_b) begin
			state_q <= ST_RUN;
			cke_prev_q <= 1'b1;
			rd_block_q <= {`DMRC_CNT_W{1'b0}};
			bank_open_q <= `DMRC_BANKS_NONE;
			refresh_feature_mode_q <= `DMRC_RESET_ZERO;
			spare_mode_three_q <= `DMRC_RESET_ZERO;
			hot_selfrefresh_rate_en <= 1'b0;
			partial_region_select <= `DMRC_PARTIAL_REGION_SELECT_FULL;
			emr2_valid_q <= 1'b0;
			emr3_valid_q <= 1'b0;
			out_disable_q <= 1'b0;
			ocd_cal_active_q <= 1'b0;
			cmd_strobe_q <= 1'b0;
			cmd_code_q <= `DMRC_CMD_NOP;
			cmd_bank_q <= 2'h0;
			cmd_row_q <= 14'h0_000;
			cmd_col_q <= 10'h000;
			cmd_auto_pre_q <= 1'b0;
			cmd_pre_all_q <= 1'b0;
			in_self_refresh_q <= 1'b0;
			in_power_down_q <= 1'b0;
			region_limited_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			cmd_strobe_q <= 1'b0;
			if (ck_rise) begin
				state_q <= state_d;
				cke_prev_q <= cke_s;
				bank_open_q <= bank_open_d;
				in_self_refresh_q <= state_d[2];
				in_power_down_q <= state_d[1];
				// limited retention only while self refresh with a partial region
				region_limited_q <= state_d[2] &&
					(partial_region_select != `DMRC_PARTIAL_REGION_SELECT_FULL);
				if (bad_d) begin
					illegal_q <= 1'b1;
				end
				if (open_bad_d) begin
					illegal_q <= 1'b1;
				end
				if ((state_q == ST_SR) && (state_d == ST_RUN)) begin
					rd_block_q <= `DMRC_READ_BLOCK_CLKS;
				end else if (rd_block_q != {`DMRC_CNT_W{1'b0}}) begin
					rd_block_q <= rd_block_q - 1'b1;
				end
				if (exec_d) begin
					cmd_strobe_q <= 1'b1;
					cmd_code_q <= cmd_s;
					cmd_bank_q <= ba_s;
					cmd_row_q <= row_eff;
					cmd_col_q <= a_s[`DMRC_A_COL_HI:0];
					cmd_auto_pre_q <= a_s[`DMRC_A_PRE_ALL];
					cmd_pre_all_q <= (cmd_s == `DMRC_CMD_PRE) && a_s[`DMRC_A_PRE_ALL];
				end
				if (is_mrs) begin
					case (ba_s)
						`DMRC_BA_EMR1: begin
							out_disable_q <= a_s[`DMRC_A_OUT_DIS];
							if (ocd_f == `DMRC_OCD_DEFAULT) begin
								ocd_cal_active_q <= 1'b1;
							end else if (ocd_f == `DMRC_OCD_EXIT) begin
								ocd_cal_active_q <= 1'b0;
							end
							if (WIDE_PART && a_s[`DMRC_A_RSTROBE]) begin
								illegal_q <= 1'b1;
							end
						end
						`DMRC_BA_EMR2: begin
							refresh_feature_mode_q <= a_s;
							hot_selfrefresh_rate_en <= a_s[`DMRC_A_HOT_SRF];
							partial_region_select <= a_s[`DMRC_A_PARTIAL_REGION_SELECT_HI:0];
							emr2_valid_q <= 1'b1;
							if (((a_s & `DMRC_EMR2_RSVD_MASK) != 14'h0_000) ||
								(a_s[`DMRC_A_PARTIAL_REGION_SELECT_HI:0] == `DMRC_PARTIAL_REGION_SELECT_UNDEF)) begin
								illegal_q <= 1'b1;
							end
						end
						`DMRC_BA_EMR3: begin
							spare_mode_three_q <= a_s;
							emr3_valid_q <= 1'b1;
							if ((a_s & `DMRC_EMR3_RSVD_MASK) != 14'h0_000) begin
								illegal_q <= 1'b1;
							end
						end
						default: begin
							cmd_auto_pre_q <= cmd_auto_pre_q;
						end
					endcase
				end
			end
		end
	end
endmodule // dmrc_decode

// *** dv/dmrc_decode_chk.sv ***
/* assertions on the decoder outputs.
   bound to every dmrc_decode instance below. */
`timescale 1ns/10ps
`include "dmrc_map.vh"
module dmrc_decode_chk (
	input wire core_clk,
	input wire rst_b,
	input wire hot_selfrefresh_rate_en,
	input wire [2:0] partial_region_select,
	input wire [13:0] refresh_feature_mode_q,
	input wire [13:0] spare_mode_three_q,
	input wire emr2_valid_q,
	input wire out_disable_q,
	input wire ocd_cal_active_q,
	input wire cmd_strobe_q,
	input wire [3:0] cmd_code_q,
	input wire [1:0] cmd_bank_q,
	input wire in_self_refresh_q,
	input wire region_limited_q,
	input wire illegal_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire mrs = cmd_strobe_q && cmd_code_q == `DMRC_CMD_MRS;
	strobe_pulse_a: assert property (cmd_strobe_q |=> !cmd_strobe_q)
		else $error("strobe too long");
	hot_bit_a: assert property (hot_selfrefresh_rate_en == refresh_feature_mode_q[7])
		else $error("hot rate bit");
	region_bits_a: assert property (partial_region_select == refresh_feature_mode_q[2:0])
		else $error("region bits");
	emr2_hold_a: assert property (!$stable(refresh_feature_mode_q) |->
		mrs && cmd_bank_q == `DMRC_BA_EMR2) else $error("emr2 changed");
	emr3_hold_a: assert property (!$stable(spare_mode_three_q) |->
		mrs && cmd_bank_q == `DMRC_BA_EMR3) else $error("emr3 changed");
	emr2_valid_a: assert property ($rose(emr2_valid_q) |->
		mrs && cmd_bank_q == `DMRC_BA_EMR2) else $error("emr2 valid");
	ocd_exit_a: assert property ($fell(ocd_cal_active_q) |->
		mrs && cmd_bank_q == `DMRC_BA_EMR1) else $error("ocd exit");
	out_dis_a: assert property (!$stable(out_disable_q) |->
		mrs && cmd_bank_q == `DMRC_BA_EMR1) else $error("out disable");
	error_sticky_a: assert property (illegal_q |=> illegal_q)
		else $error("error dropped");
	self_ref_a: assert property (in_self_refresh_q |-> !cmd_strobe_q)
		else $error("strobe in self refresh");
	region_lim_a: assert property (region_limited_q |-> in_self_refresh_q)
		else $error("region limit outside self refresh");
endmodule // dmrc_decode_chk
bind dmrc_decode dmrc_decode_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
	.hot_selfrefresh_rate_en(hot_selfrefresh_rate_en),
	.partial_region_select(partial_region_select),
	.refresh_feature_mode_q(refresh_feature_mode_q), .spare_mode_three_q(spare_mode_three_q),
	.emr2_valid_q(emr2_valid_q), .out_disable_q(out_disable_q),
	.ocd_cal_active_q(ocd_cal_active_q), .cmd_strobe_q(cmd_strobe_q), .cmd_code_q(cmd_code_q),
	.cmd_bank_q(cmd_bank_q), .in_self_refresh_q(in_self_refresh_q),
	.region_limited_q(region_limited_q), .illegal_q(illegal_q));

// *** dv/dmrc_ctl_model.sv ***
/* memory controller model: free running memory clock and command pins.
   assumes core_clk is the bench clock; pins change at its falling edge. */
`timescale 1ns/10ps
`include "dmrc_map.vh"
module dmrc_ctl_model (
	input wire logic core_clk,
	output logic mem_ck,
	output logic cke,
	output logic cs_b,
	output logic ras_b,
	output logic cas_b,
	output logic we_b,
	output logic [1:0] ba,
	output logic [13:0] addr
);
	initial begin
		mem_ck = 1'b0;
		forever #400 mem_ck = ~mem_ck;
	end
	initial {cke, cs_b, ras_b, cas_b, we_b, ba, addr} = {5'h1F, 16'h0000};
	// one command per clock, then nop with scrambled don't-care pins
	task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b,
		input logic [13:0] a);
		@(negedge mem_ck);
		@(negedge core_clk);
		{cke, cs_b, ras_b, cas_b, we_b, ba, addr} = {k, c, b, a};
		@(negedge mem_ck);
		@(negedge core_clk);
		{cs_b, ras_b, cas_b, we_b, ba, addr} = {`DMRC_CMD_NOP, ~b, ~a};
	endtask
endmodule // dmrc_ctl_model

// *** dv/tb_top.sv ***
/* self-checking bench for the command decoder.
   assumes the checker binds itself and the controller model drives the pins. */
`timescale 1ns/10ps
`include "dmrc_map.vh"
module tb_top;
	logic core_clk, rst_b;
	wire mem_ck, cke, cs_b, ras_b, cas_b, we_b, hot, e2v, e3v, odis, ocd, stb;
	wire apre, pall, in_sr, in_pd, rlim, ill;
	wire [1:0] ba, bank;
	wire [2:0] rsel;
	wire [3:0] code;
	wire [9:0] col;
	wire [13:0] addr, e2, e3, row;
	int n_errors = 0, checks_done = 0, cyc = 0;
	int n_stb = 0, s0 = 0;
	// strobe counted mid-cycle, away from the edge that launches it
	always @(negedge core_clk) begin
		if (stb === 1'b1) begin
			n_stb++;
		end
	end
	dmrc_ctl_model ctl (.core_clk(core_clk), .mem_ck(mem_ck), .cke(cke), .cs_b(cs_b),
		.ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr));
	dmrc_decode #(.WIDE_PART(1'b0)) dut (.core_clk(core_clk), .rst_b(rst_b), .mem_ck(mem_ck),
		.cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr),
		.hot_selfrefresh_rate_en(hot), .partial_region_select(rsel),
		.refresh_feature_mode_q(e2), .spare_mode_three_q(e3), .emr2_valid_q(e2v),
		.emr3_valid_q(e3v), .out_disable_q(odis), .ocd_cal_active_q(ocd), .cmd_strobe_q(stb),
		.cmd_code_q(code), .cmd_bank_q(bank), .cmd_row_q(row), .cmd_col_q(col),
		.cmd_auto_pre_q(apre), .cmd_pre_all_q(pall), .in_self_refresh_q(in_sr),
		.in_power_down_q(in_pd), .region_limited_q(rlim), .illegal_q(ill));
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic k, input logic [3:0] c, input logic [1:0] b,
		input logic [13:0] a);
		ctl.issue(k, c, b, a);
		repeat (6) @(negedge core_clk);
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_emr2();
		chk(e2v, 0);
		chk(e3v, 0);
		go(1, `DMRC_CMD_PRE, 0, 14'h0400);
		chk(pall, 1);
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR2, 14'h0081);
		chk(e2, 14'h0081);
		chk(hot, 1);
		chk(e2v, 1);
		for (int r = 0; r < 8; r++) begin
			if (r != 3) begin
				go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR2, 14'(r));
				chk(rsel, 14'(r));
				chk(hot, 0);
			end
		end
	endtask
	task automatic t_emr13();
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR3, 14'h0000);
		chk(e3v, 1);
		chk(e3, 14'h0000);
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR1, 14'h1380);
		chk(odis, 1);
		chk(ocd, 1);
		chk(e2, 14'h0007);
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR1, 14'h0000);
		chk(ocd, 0);
		chk(odis, 0);
	endtask
	task automatic t_cmds();
		s0 = n_stb;
		go(1, `DMRC_CMD_ACT, 2'h1, 14'h2ABC);
		chk({code, bank, row[7:0]}, 14'h0DBC);
		chk(row, 14'h2ABC);
		go(1, `DMRC_CMD_WR, 2'h2, 14'h0555);
		chk({apre, code, col[8:0]}, 14'h2955);
		go(1, `DMRC_CMD_RD, 2'h3, 14'h02AA);
		chk({apre, code[2:0], col}, 14'h16AA);
		chk(code, `DMRC_CMD_RD);
		go(1, `DMRC_CMD_PRE, 2'h1, 14'h0000);
		chk(pall, 0);
		go(1, `DMRC_CMD_REF, 2'h0, 14'h0000);
		chk(code, `DMRC_CMD_REF);
		// earlier trailing nop, five commands and four trailing nops
		chk(14'(n_stb - s0), 14'h000A);
	endtask
	task automatic t_power();
		repeat (2) go(0, `DMRC_CMD_NOP, 0, 0);
		chk(in_pd, 1);
		go(1, `DMRC_CMD_NOP, 0, 0);
		chk(in_pd, 0);
		go(1, `DMRC_CMD_PRE, 0, 14'h0400);
		go(0, `DMRC_CMD_REF, 0, 0);
		chk({in_sr, rlim}, 3);
		go(0, `DMRC_CMD_NOP, 0, 0);
		go(1, `DMRC_CMD_NOP, 0, 0);
		chk({in_sr, ill}, 0);
		go(1, `DMRC_CMD_RD, 0, 0);
		chk(ill, 1);
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR2, 14'h0100);
		chk({e2[12:0], ill}, 14'h0201);
	endtask
	task automatic pulse_reset();
		rst_b = 1'b0;
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
	endtask
	// each flag is provoked alone, after a reset that clears the sticky error
	task automatic t_flags();
		pulse_reset();
		chk(code, `DMRC_CMD_NOP);
		chk(ill, 0);
		chk({e2v, e3v}, 0);
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR2, 14'h0100);
		chk({e2[12:0], ill}, 14'h0201);
		pulse_reset();
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR3, 14'h0001);
		chk({e3[12:0], ill}, 14'h0003);
		pulse_reset();
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR2, 14'h0003);
		chk({rsel, ill}, 14'h0007);
		pulse_reset();
		go(1, `DMRC_CMD_ACT, 2'h1, 14'h0000);
		chk(ill, 0);
		go(1, `DMRC_CMD_MRS, `DMRC_BA_EMR2, 14'h0000);
		chk(ill, 1);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 1500) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		rst_b = 1'b0;
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
		chk(code, `DMRC_CMD_NOP);
		t_emr2();
		t_emr13();
		t_cmds();
		t_power();
		t_flags();
		final_report();
	end
endmodule // tb_top
